// ---- rtl/qrb_regs.svh ----
// Constants of the query read-back link: query addresses, parameter codes,
// response layout and the host controller's own register map.
// Assumes inclusion by bare name from any file that needs them.
`ifndef QRB_REGS_SVH
`define QRB_REGS_SVH

`define QRB_Q_RF_PARAM 8'h20
`define QRB_Q_TEMP 8'h21
`define QRB_Q_STATUS 8'h22
`define QRB_Q_INFO 8'h23
`define QRB_Q_LIST_BUF 8'h24
`define QRB_Q_LEVEL_DAC 8'h25
`define QRB_Q_SERIAL_OUT 8'h26

`define QRB_RSP_BYTES 3'h5
`define QRB_PCODE_MSB 3
`define QRB_STAT_SEL_BIT 0

`define QRB_P_RF_FREQ 4'h0
`define QRB_P_SWEEP_START 4'h1
`define QRB_P_SWEEP_STOP 4'h2
`define QRB_P_SWEEP_STEP 4'h3
`define QRB_P_DWELL 4'h4
`define QRB_P_CYCLES 4'h5
`define QRB_P_LIST_PTS 4'h6
`define QRB_P_LEVEL 4'h7
`define QRB_P_RF2_FREQ 4'h8
`define QRB_P_PHASE 4'ha

`define QRB_HR_ADDR 4'h0
`define QRB_HR_WRITE 4'h1
`define QRB_HR_READ 4'h2
`define QRB_HR_STATUS 4'h3
`define QRB_HR_CTRL 4'h4
`define QRB_HR_DATA_HI 4'h5
`define QRB_HR_DATA_LO 4'h6

`endif

// ---- rtl/qrb_pkg.sv ----
// Types for the two ends of the query read-back link, one state type for each end.
// Assumes nothing of its surroundings.
package qrb_pkg;
  typedef enum logic {QRB_DEV_IDLE, QRB_DEV_SEND} qrb_dev_state_type;
  typedef enum logic [1:0] {QRB_HOST_IDLE, QRB_HOST_REQ, QRB_HOST_COLLECT} qrb_host_state_type;
endpackage : qrb_pkg

// ---- rtl/qrb_link_if.sv ----
// Link between the query host controller and the query device.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface qrb_link_if;
  logic req_valid;
  logic req_read;
  logic [7:0] req_addr;
  logic [7:0] req_data;
  logic req_ready;
  logic rsp_valid;
  logic [7:0] rsp_data;
  logic rsp_ready;
  modport dev (input req_valid, input req_read, input req_addr, input req_data,
    output req_ready, output rsp_valid, output rsp_data, input rsp_ready);
  modport host (output req_valid, output req_read, output req_addr, output req_data,
    input req_ready, input rsp_valid, input rsp_data, output rsp_ready);
endinterface : qrb_link_if

// ---- rtl/qrb_device.sv ----
// Device end of the query link: builds five-byte responses and streams them.
// Assumes user-side values come from logic on SYS_CLK and the host keeps the link order.
`timescale 1ns/100ps
`include "qrb_regs.svh"

module qrb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;
  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else if (ce) begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem_q[wr_q] <= in_data;
    end
  end
endmodule : qrb_fifo

// Summary of operation
// - Write request, then separate read returns data.
// - Responses are five bytes, MSB first.
// - Short responses padded with trailing zero bytes.
// - Host reads all five bytes each query.
// - Low nibble selects parameter; upper nibble zero.
// - Codes 0-3 return frequencies, five bytes.
// - Codes 4-6 return four bytes, one zero.
// - Code 7 level; code 8 two-byte frequency.
// - Code 0xA returns raw float phase bits.
// - Forty bits hold unsigned parameter value.
// - Temperature float in bits 39:8, byte zero.
// - SPI status goes to serial output buffer.
// - Bits 39:36 report list trigger flags.
// - Bits 35:32 report list waveform flags.
// - Status bit0 set returns reference configuration.
module qrb_device (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic LINK_IS_SPI,
  input wire logic [39:0] RF_FREQ,
  input wire logic [39:0] SWEEP_START,
  input wire logic [39:0] SWEEP_STOP,
  input wire logic [39:0] SWEEP_STEP,
  input wire logic [31:0] DWELL_TIME,
  input wire logic [31:0] CYCLE_COUNT,
  input wire logic [31:0] LIST_POINTS,
  input wire logic [31:0] RF_LEVEL,
  input wire logic [15:0] RF2_FREQ,
  input wire logic [31:0] PHASE_BITS,
  input wire logic [31:0] TEMP_BITS,
  input wire logic [7:0] LIST_CFG,
  input wire logic [21:0] OPERATE_STATUS,
  input wire logic [3:0] REF_CFG,
  output logic BUSY,
  qrb_link_if.dev LINK
);
  qrb_pkg::qrb_dev_state_type state_q;
  logic [2:0] left_q;
  logic [39:0] rb_q;
  logic [39:0] sob_q;
  logic [39:0] resp;
  logic req_ready_q;
  logic take;
  logic push;
  logic fifo_ready;
  logic fifo_valid;

  assign take = LINK.req_valid && req_ready_q;
  assign push = (state_q == qrb_pkg::QRB_DEV_SEND) && fifo_ready;
  assign LINK.req_ready = req_ready_q;

  always_comb begin
    resp = '0;
    unique case (LINK.req_addr)
      `QRB_Q_RF_PARAM: begin
        case (LINK.req_data[`QRB_PCODE_MSB:0])
          `QRB_P_RF_FREQ: resp = RF_FREQ;
          `QRB_P_SWEEP_START: resp = SWEEP_START;
          `QRB_P_SWEEP_STOP: resp = SWEEP_STOP;
          `QRB_P_SWEEP_STEP: resp = SWEEP_STEP;
          `QRB_P_DWELL: resp = {DWELL_TIME, 8'h00};
          `QRB_P_CYCLES: resp = {CYCLE_COUNT, 8'h00};
          `QRB_P_LIST_PTS: resp = {LIST_POINTS, 8'h00};
          `QRB_P_LEVEL: resp = {RF_LEVEL, 8'h00};
          `QRB_P_RF2_FREQ: resp = {RF2_FREQ, 24'h000000};
          `QRB_P_PHASE: resp = {PHASE_BITS, 8'h00};
          default: resp = '0;
        endcase
      end
      `QRB_Q_TEMP: resp = {TEMP_BITS, 8'h00};
      `QRB_Q_STATUS: begin
        if (LINK.req_data[`QRB_STAT_SEL_BIT]) begin
          resp = {27'h0, REF_CFG[3:2], 1'b0, REF_CFG[1:0], 8'h00};
        end else begin
          resp = {LIST_CFG, 2'b00, OPERATE_STATUS, 8'h00};
        end
      end
      default: resp = '0;
    endcase
  end

  // Shifting the buffer out leaves it zero, so a repeated read never replays stale data.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rb_q <= '0;
    end else if (CE) begin
      if (take && !LINK.req_read) begin
        if (LINK.req_addr == `QRB_Q_SERIAL_OUT) begin
          rb_q <= sob_q;
        end else if (LINK.req_addr == `QRB_Q_STATUS && LINK_IS_SPI) begin
          rb_q <= '0;
        end else begin
          rb_q <= resp;
        end
      end else if (push) begin
        rb_q <= {rb_q[31:0], 8'h00};
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      sob_q <= '0;
    end else if (CE && take && !LINK.req_read) begin
      if (LINK.req_addr == `QRB_Q_STATUS && LINK_IS_SPI) begin
        sob_q <= resp;
      end else if (LINK.req_addr == `QRB_Q_SERIAL_OUT) begin
        sob_q <= '0;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= qrb_pkg::QRB_DEV_IDLE;
      left_q <= '0;
    end else if (CE) begin
      unique case (state_q)
        qrb_pkg::QRB_DEV_IDLE: begin
          if (take && LINK.req_read) begin
            state_q <= qrb_pkg::QRB_DEV_SEND;
            left_q <= `QRB_RSP_BYTES;
          end
        end
        qrb_pkg::QRB_DEV_SEND: begin
          if (push) begin
            left_q <= left_q - 3'h1;
            if (left_q == 3'h1) begin
              state_q <= qrb_pkg::QRB_DEV_IDLE;
            end
          end
        end
      endcase
    end
  end

  // New requests wait until every byte has left the buffer.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      req_ready_q <= 1'b0;
      BUSY <= 1'b0;
    end else if (CE) begin
      req_ready_q <= !take && state_q == qrb_pkg::QRB_DEV_IDLE && !fifo_valid;
      BUSY <= state_q == qrb_pkg::QRB_DEV_SEND || fifo_valid;
    end
  end

  qrb_fifo #(.WIDTH(8), .DEPTH(2)) u_fifo (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .ce(CE),
    .in_valid(push),
    .in_ready(fifo_ready),
    .in_data(rb_q[39:32]),
    .out_valid(fifo_valid),
    .out_ready(LINK.rsp_ready),
    .out_data(LINK.rsp_data)
  );
  assign LINK.rsp_valid = fifo_valid;
endmodule : qrb_device

// ---- rtl/qrb_host.sv ----
// Host end of the query link: software orders queries through a small register port.
// Assumes the software port and the link share SYS_CLK.
`timescale 1ns/100ps
`include "qrb_regs.svh"

module qrb_host (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic [3:0] ADDR,
  input wire logic [31:0] WR_DATA,
  input wire logic WR_EN,
  input wire logic RD_EN,
  output logic [31:0] RD_DATA,
  qrb_link_if.host LINK
);
  qrb_pkg::qrb_host_state_type state_q;
  logic req_valid_q;
  logic req_read_q;
  logic [7:0] qaddr_q;
  logic [7:0] qdata_q;
  logic rsp_ready_q;
  logic hold_q;
  logic done_q;
  logic [2:0] got_q;
  logic [39:0] data_q;
  logic taken;
  logic got_byte;
  logic idle;
  logic issue_wr;
  logic issue_rd;

  assign idle = state_q == qrb_pkg::QRB_HOST_IDLE;
  assign taken = req_valid_q && LINK.req_ready;
  assign got_byte = LINK.rsp_valid && rsp_ready_q;
  assign issue_wr = WR_EN && idle && ADDR == `QRB_HR_WRITE;
  assign issue_rd = WR_EN && idle && ADDR == `QRB_HR_READ;
  assign LINK.req_valid = req_valid_q;
  assign LINK.req_read = req_read_q;
  assign LINK.req_addr = qaddr_q;
  assign LINK.req_data = qdata_q;
  assign LINK.rsp_ready = rsp_ready_q;

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      qaddr_q <= '0;
      qdata_q <= '0;
      hold_q <= 1'b0;
    end else if (CE && WR_EN) begin
      if (idle && ADDR == `QRB_HR_ADDR) begin
        qaddr_q <= WR_DATA[7:0];
      end
      if (issue_wr) begin
        qdata_q <= WR_DATA[7:0];
      end
      if (ADDR == `QRB_HR_CTRL) begin
        hold_q <= WR_DATA[0];
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= qrb_pkg::QRB_HOST_IDLE;
      req_valid_q <= 1'b0;
      req_read_q <= 1'b0;
    end else if (CE) begin
      unique case (state_q)
        qrb_pkg::QRB_HOST_IDLE: begin
          if (issue_wr || issue_rd) begin
            state_q <= qrb_pkg::QRB_HOST_REQ;
            req_valid_q <= 1'b1;
            req_read_q <= issue_rd;
          end
        end
        qrb_pkg::QRB_HOST_REQ: begin
          if (taken) begin
            req_valid_q <= 1'b0;
            state_q <= req_read_q ? qrb_pkg::QRB_HOST_COLLECT : qrb_pkg::QRB_HOST_IDLE;
          end
        end
        qrb_pkg::QRB_HOST_COLLECT: begin
          if (got_byte && got_q == `QRB_RSP_BYTES - 3'h1) begin
            state_q <= qrb_pkg::QRB_HOST_IDLE;
          end
        end
        default: state_q <= qrb_pkg::QRB_HOST_IDLE;
      endcase
    end
  end

  // Every read drains all five bytes before a new query can be issued.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      got_q <= '0;
      data_q <= '0;
      done_q <= 1'b0;
      rsp_ready_q <= 1'b0;
    end else if (CE) begin
      if (issue_rd) begin
        got_q <= '0;
        done_q <= 1'b0;
      end else if (got_byte) begin
        got_q <= got_q + 3'h1;
        data_q <= {data_q[31:0], LINK.rsp_data};
        if (got_q == `QRB_RSP_BYTES - 3'h1) begin
          done_q <= 1'b1;
        end
      end
      rsp_ready_q <= state_q == qrb_pkg::QRB_HOST_COLLECT && !hold_q &&
        !(got_byte && got_q == `QRB_RSP_BYTES - 3'h1);
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      RD_DATA <= '0;
    end else if (CE) begin
      RD_DATA <= '0;
      if (RD_EN) begin
        unique case (ADDR)
          `QRB_HR_ADDR: RD_DATA <= {24'h000000, qaddr_q};
          `QRB_HR_STATUS: RD_DATA <= {25'h0, got_q, 2'b00, done_q, !idle};
          `QRB_HR_CTRL: RD_DATA <= {31'h0, hold_q};
          `QRB_HR_DATA_HI: RD_DATA <= {24'h000000, data_q[39:32]};
          `QRB_HR_DATA_LO: RD_DATA <= data_q[31:0];
          default: RD_DATA <= '0;
        endcase
      end
    end
  end
endmodule : qrb_host

// ---- verif/qrb_checker.sv ----
// Concurrent checks on the query link between the host and device ends.
// Assumes one clock, an active-low reset and CE held high on both ends.
`timescale 1ns/100ps
module qrb_checker (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic req_valid,
  input wire logic req_read,
  input wire logic [7:0] req_addr,
  input wire logic [7:0] req_data,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_data,
  input wire logic rsp_ready
);
  logic [2:0] cnt_q;
  logic rd_tk;
  logic wr_tk;
  logic byte_tk;
  assign rd_tk = req_valid && req_ready && req_read;
  assign wr_tk = req_valid && req_ready && !req_read;
  assign byte_tk = rsp_valid && rsp_ready;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  // A read restarts the count, so a lost byte is caught in its own response and never skews the next one.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N)
      cnt_q <= 3'h0;
    else if (rd_tk)
      cnt_q <= 3'h0;
    else if (byte_tk)
      cnt_q <= cnt_q + 3'h1;
  end
  chk_req_hold: assert property (
    req_valid && !req_ready |=> req_valid && $stable({req_read, req_addr, req_data}))
    else $error("Request changed before it was taken.");
  chk_write_gap: assert property (
    wr_tk |=> !req_ready ##1 req_ready)
    else $error("Ready did not drop for exactly one cycle after a write.");
  chk_read_start: assert property (
    rd_tk |=> !rsp_valid ##1 rsp_valid)
    else $error("First response byte not two cycles after the read.");
  chk_rsp_hold: assert property (
    rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data))
    else $error("Response byte changed while stalled.");
  chk_stream_on: assert property (
    byte_tk && cnt_q < 3'h4 |=> rsp_valid)
    else $error("Response ended before five bytes.");
  chk_five_end: assert property (
    byte_tk && cnt_q == 3'h4 |=> !rsp_valid)
    else $error("Response ran past five bytes.");
  chk_ready_back: assert property (
    byte_tk && cnt_q == 3'h4 |-> ##[1:3] req_ready)
    else $error("Device did not accept requests after the fifth byte.");
  chk_no_req_busy: assert property (
    rsp_valid |-> !req_ready)
    else $error("Request accepted while response bytes remain.");
  cov_read: cover property (rd_tk);
  cov_write: cover property (wr_tk);
  cov_stall: cover property (rsp_valid && !rsp_ready);
endmodule : qrb_checker

// ---- verif/query_register_readback_tb_top.sv ----
// Self-checking bench: host and device ends joined by the query link.
// Assumes the design files and the checker are compiled before it.
`timescale 1ns/100ps
`include "qrb_regs.svh"
module query_register_readback_tb_top;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic spi = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wr_data = 32'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [31:0] rd_data;
  logic busy;
  logic [39:0] fr [4];
  logic [31:0] w32 [6];
  logic [15:0] rf2;
  logic [7:0] lcfg;
  logic [21:0] ops;
  logic [3:0] ref_cfg;
  logic [39:0] exq [$];
  logic [39:0] rq [$];
  logic chk_q = 1'b0;
  logic chk_d = 1'b0;
  logic [39:0] sh;
  int nb = 0;
  int errors = 0;
  int compares = 0;
  qrb_link_if lk();
  qrb_device qrb_device_inst (.SYS_CLK(sys_clk), .RST_N(rst_n), .CE(1'b1),
    .LINK_IS_SPI(spi), .RF_FREQ(fr[0]), .SWEEP_START(fr[1]), .SWEEP_STOP(fr[2]),
    .SWEEP_STEP(fr[3]), .DWELL_TIME(w32[0]), .CYCLE_COUNT(w32[1]), .LIST_POINTS(w32[2]),
    .RF_LEVEL(w32[3]), .RF2_FREQ(rf2), .PHASE_BITS(w32[4]), .TEMP_BITS(w32[5]),
    .LIST_CFG(lcfg), .OPERATE_STATUS(ops), .REF_CFG(ref_cfg), .BUSY(busy), .LINK(lk));
  qrb_host qrb_host_inst (.SYS_CLK(sys_clk), .RST_N(rst_n), .CE(1'b1), .ADDR(addr),
    .WR_DATA(wr_data), .WR_EN(wr_en), .RD_EN(rd_en), .RD_DATA(rd_data), .LINK(lk));
  qrb_checker qrb_checker_inst (.SYS_CLK(sys_clk), .RST_N(rst_n),
    .req_valid(lk.req_valid), .req_read(lk.req_read), .req_addr(lk.req_addr),
    .req_data(lk.req_data), .req_ready(lk.req_ready), .rsp_valid(lk.rsp_valid),
    .rsp_data(lk.rsp_data), .rsp_ready(lk.rsp_ready));
  always #10 sys_clk = ~sys_clk;
  task automatic summarize();
    if (errors == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize
  task automatic check(input logic [39:0] got, input logic [39:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  function automatic logic [39:0] exp_rf(input logic [3:0] c);
    if (c < 4'h4) return fr[c[1:0]];
    if (c < 4'h8) return {w32[c - 4'h4], 8'h00};
    if (c == 4'h8) return {rf2, 24'h0};
    if (c == 4'ha) return {w32[4], 8'h00};
    return 40'h0;
  endfunction : exp_rf
  function automatic logic [39:0] st(input logic ref_sel);
    if (ref_sel) return {27'h0, ref_cfg[3:2], 1'b0, ref_cfg[1:0], 8'h00};
    return {lcfg, 2'b00, ops, 8'h00};
  endfunction : st
  // Strobes drop for one edge between calls so no signal is assigned twice in a step.
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
    @(posedge sys_clk);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic c, output logic [31:0] d);
    addr <= a;
    rd_en <= 1'b1;
    chk_q <= c;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1 d = rd_data;
    @(posedge sys_clk);
  endtask : rd
  task automatic poll(input int b, input logic v);
    logic [31:0] d;
    int n;
    for (n = 0; n < 60; n++) begin
      rd(`QRB_HR_STATUS, 1'b0, d);
      if (d[b] === v) break;
    end
    if (n == 60) errors++;
  endtask : poll
  task automatic rsp(input logic [39:0] e, input logic hold);
    logic [31:0] d;
    exq.push_back(e);
    if (hold) wr(`QRB_HR_CTRL, 32'h1);
    wr(`QRB_HR_READ, 32'h0);
    if (hold) begin
      repeat (8) @(posedge sys_clk);
      wr(`QRB_HR_CTRL, 32'h0);
    end
    poll(1, 1'b1);
    rq.push_back(40'h52);
    rd(`QRB_HR_STATUS, 1'b1, d);
    rq.push_back({32'h0, e[39:32]});
    rd(`QRB_HR_DATA_HI, 1'b1, d);
    rq.push_back({8'h0, e[31:0]});
    rd(`QRB_HR_DATA_LO, 1'b1, d);
  endtask : rsp
  task automatic query(input logic [7:0] qa, input logic [7:0] qb, input logic [39:0] e,
      input logic hold);
    wr(`QRB_HR_ADDR, {24'h0, qa});
    wr(`QRB_HR_WRITE, {24'h0, qb});
    poll(0, 1'b0);
    rsp(e, hold);
  endtask : query
  always @(posedge sys_clk) begin
    if (chk_d) check(rd_data, rq.pop_front());
    chk_d <= rd_en && chk_q;
  end
  always @(posedge sys_clk) begin
    if (lk.rsp_valid === 1'b1 && lk.rsp_ready === 1'b1) begin
      sh = {sh[31:0], lk.rsp_data};
      check({39'h0, busy}, 40'h1);
      nb++;
      if (nb == 5) begin
        nb = 0;
        check(sh, exq.pop_front());
      end
    end
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    summarize();
  end
  initial begin
    logic [31:0] d;
    void'($urandom(10));
    @(posedge sys_clk);
    for (int i = 0; i < 4; i++) fr[i] <= {8'($urandom), $urandom};
    for (int i = 0; i < 6; i++) w32[i] <= $urandom;
    rf2 <= 16'($urandom);
    lcfg <= 8'($urandom);
    ops <= 22'($urandom);
    ref_cfg <= 4'($urandom);
    repeat (15) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    for (int c = 0; c < 16; c++) query(`QRB_Q_RF_PARAM, 8'(c), exp_rf(4'(c)), c == 5);
    query(`QRB_Q_TEMP, 8'h00, {w32[5], 8'h00}, 1'b0);
    query(`QRB_Q_STATUS, 8'h00, st(1'b0), 1'b0);
    query(`QRB_Q_STATUS, 8'h01, st(1'b1), 1'b1);
    rsp(40'h0, 1'b0);
    for (int a = 3; a < 6; a++) query(8'h20 + 8'(a), 8'h00, 40'h0, 1'b0);
    spi <= 1'b1;
    query(`QRB_Q_STATUS, 8'h00, 40'h0, 1'b0);
    query(`QRB_Q_SERIAL_OUT, 8'h00, st(1'b0), 1'b0);
    rq.push_back(40'h26);
    rd(`QRB_HR_ADDR, 1'b1, d);
    rq.push_back(40'h0);
    rd(`QRB_HR_CTRL, 1'b1, d);
    rq.push_back(40'h0);
    rd(4'h7, 1'b1, d);
    repeat (4) @(posedge sys_clk);
    check(40'(exq.size() + rq.size()), 40'h0);
    check({8'h0, rd_data}, 40'h0);
    check({39'h0, busy}, 40'h0);
    summarize();
  end
endmodule : query_register_readback_tb_top
